// ===== hdl/led_serial_pkg.sv
// Constants shared by the status LED controller
package led_serial_pkg;
  localparam int PORTS = 4;
  localparam int LEDS_PER_PORT = 4;
  localparam int PINS = PORTS * LEDS_PER_PORT;
  localparam int REG_ADDR_W = 4;
  localparam int REG_DATA_W = 16;
  // Register offsets; mode and behaviour registers take one offset per port
  localparam logic [3:0] MODE_OFS = 4'h0;
  localparam logic [3:0] BEHAV_OFS = 4'h4;
  localparam logic [3:0] EXT_CTRL_OFS = 4'h8;
  localparam logic [3:0] POLARITY_OFS = 4'h9;
  localparam logic [3:0] DRIVE_OFS = 4'ha;
  localparam logic [3:0] SWAP_OFS = 4'hb;
  localparam logic [3:0] STATE_OFS = 4'hc;
  // Field positions
  localparam int MODE_FIELD_W = 4;
  localparam int COMBINE_LSB = 0;
  localparam int STRETCH_LSB = 4;
  localparam int RATE_LSB = 8;
  localparam int EXT_EN_LSB = 12;
  localparam int BOOT_BLINK_BIT = 11;
  localparam int PULSE_EN_BIT = 4;
  localparam int PULSE_FREQ_LSB = 2;
  localparam int PULSE_WIDTH_LSB = 0;
  localparam int POLARITY_LSB = 10;
  localparam int DRIVE_BIT = 9;
  localparam int SWAP_BIT = 0;
  // Reset values
  localparam logic [15:0] MODE_RESET = 16'h0000;
  localparam logic [15:0] BEHAV_RESET = 16'h000f;
  localparam logic [15:0] EXT_CTRL_RESET = 16'h0801;
  localparam logic [15:0] POLARITY_RESET = 16'h0000;
  localparam logic [15:0] DRIVE_RESET = 16'h0200;
  localparam logic [15:0] SWAP_RESET = 16'h0000;
  // Mode codes; TX and RX activity also reach first LED pins as extended codes 23 and 24
  localparam logic [4:0] MODE_LINK_ACT = 5'h00;
  localparam logic [4:0] MODE_L1000_ACT = 5'h01;
  localparam logic [4:0] MODE_L100_ACT = 5'h02;
  localparam logic [4:0] MODE_L10_ACT = 5'h03;
  localparam logic [4:0] MODE_L100_1000 = 5'h04;
  localparam logic [4:0] MODE_L10_1000 = 5'h05;
  localparam logic [4:0] MODE_L10_100 = 5'h06;
  localparam logic [4:0] MODE_RSVD_A = 5'h07;
  localparam logic [4:0] MODE_DUPLEX_COL = 5'h08;
  localparam logic [4:0] MODE_COLLISION = 5'h09;
  localparam logic [4:0] MODE_ACTIVITY = 5'h0a;
  localparam logic [4:0] MODE_RSVD_B = 5'h0b;
  localparam logic [4:0] MODE_ANEG_FAULT = 5'h0c;
  localparam logic [3:0] MODE_SERIAL = 4'hd;
  localparam logic [4:0] MODE_FORCE_OFF = 5'h0e;
  localparam logic [4:0] MODE_FORCE_ON = 5'h0f;
  localparam logic [4:0] MODE_L1000X = 5'h10;
  localparam logic [4:0] MODE_L100FX = 5'h11;
  localparam logic [4:0] MODE_ACT_1000X = 5'h12;
  localparam logic [4:0] MODE_ACT_100FX = 5'h13;
  localparam logic [4:0] MODE_X_FORCE_OFF = 5'h14;
  localparam logic [4:0] MODE_X_FORCE_ON = 5'h15;
  localparam logic [4:0] MODE_TX_ACT = 5'h17;
  localparam logic [4:0] MODE_RX_ACT = 5'h18;
  // Serial stream
  localparam int SLOTS_PER_PORT = 12;
  localparam int SLOTS = PORTS * SLOTS_PER_PORT;
  localparam int SER_HALF_CYC = 8;
  localparam int ANEG_SLOT = 11;
  // Timing at the core clock
  localparam int CLK_HZ = 40_000_000;
  localparam int BASE_TICK_US = 25_000;
  localparam int BASE_TICK_CYC = BASE_TICK_US * (CLK_HZ / 1_000_000);
  localparam int BOOT_BLINK_MS = 1000;
  localparam int BOOT_TICKS = BOOT_BLINK_MS * 1000 / BASE_TICK_US;
  localparam int PULSE_HZ = 5000;
  localparam int PULSE_PERIOD_CYC = CLK_HZ / PULSE_HZ;
  localparam int PULSE_STEP_PCT = 10;
  localparam int PULSE_STEP_CYC = PULSE_PERIOD_CYC * PULSE_STEP_PCT / 100;
  typedef enum logic [2:0] {
    SER_IDLE = 3'b001,
    SER_LOW = 3'b010,
    SER_HIGH = 3'b100
  } ser_state_type;
endpackage : led_serial_pkg

// ===== hdl/led_status_serializer.sv
// Per-port status LED controller with serial status stream
//
// Operation
// - Port 0 first LED mode field 0xD selects serial mode.
// - Serial mode puts data on port 0 first LED, clock on second.
// - All other LED pins keep their own modes during serial mode.
// - Frames hold 48 bits, each stable across the serial clock rise.
// - Each port's first LED combine and blink/stretch govern its serial bits.
// - Twelve slots per port, ports in order (reversed when swap bit 0 is set), fixed signal order within.
// - Bits 15..12 switch each first LED pin into the extended mode set.
// - Extended effective mode is sixteen plus the four-bit field.
// - Modes 16, 17 assert for 1000BASE-X and 100BASE-FX links.
// - Modes 18, 19 blink or stretch on fibre activity, else off.
// - Mode 20 forces off, 21 forces on without pulsing, 22 reserved.
// - Global swap bit 0 reverses the port order of LED mapping.
// - Combine, or an activity-only mode, shows primary and blinks on secondary; otherwise primary only.
// - Blink toggles with equal on and off halves.
// - Stretch holds on and off states at least the programmed period.
// - Blink rates 2.5, 5, 10 or 20 Hz.
// - Stretch lengths 50, 100, 200 or 400 ms.
// - Port 0 rate selection applies to every pin; others ignored.
// - Pulsing drives asserted LEDs at 5 kHz, 20 percent duty.
// - LEDs not in a force mode blink one second after reset unless bit 11 is cleared.
// - Pulse width and repetition frequency are programmable.
// - LEDs are active low by default; bits 13..10 invert polarity.
// - Drive bit 9 tristates inactive LEDs when set, else drives them at their inactive level.
`timescale 1ns/1ps
`default_nettype none
module led_status_serializer #(
  parameter int BASE_TICK_CYC = led_serial_pkg::BASE_TICK_CYC,
  parameter int SER_HALF_CYC = led_serial_pkg::SER_HALF_CYC
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [led_serial_pkg::REG_ADDR_W-1:0] reg_addr,
  input wire logic [led_serial_pkg::REG_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [led_serial_pkg::REG_DATA_W-1:0] reg_rdata,
  input wire logic [3:0] link1000,
  input wire logic [3:0] link100,
  input wire logic [3:0] link10,
  input wire logic [3:0] link_1000x,
  input wire logic [3:0] link_100fx,
  input wire logic [3:0] full_duplex,
  input wire logic [3:0] collision,
  input wire logic [3:0] tx_activity,
  input wire logic [3:0] rx_activity,
  input wire logic [3:0] activity_1000x,
  input wire logic [3:0] activity_100fx,
  input wire logic [3:0] aneg_fault,
  output logic [led_serial_pkg::PINS-1:0] led_out,
  output logic [led_serial_pkg::PINS-1:0] led_oe
);
  localparam int TICK_W = $clog2(BASE_TICK_CYC + 1);
  localparam int HALF_W = $clog2(SER_HALF_CYC + 1);
  localparam int NPIN = led_serial_pkg::PINS;

  // Data change and clock rise are both two registers late, so three cycles keep setup
  generate
    if (SER_HALF_CYC < 3 || BASE_TICK_CYC < 2) begin : g_bad_param
      $error("led_status_serializer: SER_HALF_CYC >= 3 and BASE_TICK_CYC >= 2 required");
    end
  endgenerate

  // Returns {primary, secondary, activity_only, no_pulse}
  function automatic logic [3:0] mode_terms(input logic [4:0] mode, input logic [4:0] lnk,
                                            input logic fd, input logic fault,
                                            input logic [4:0] act);
    logic any_link;
    logic trx;
    logic [3:0] t;
    any_link = |lnk;
    trx = act[1] | act[2];
    t = 4'h0;
    case (mode)
      led_serial_pkg::MODE_LINK_ACT: t = {any_link, any_link & trx, 2'b00};
      led_serial_pkg::MODE_L1000_ACT: t = {lnk[0], lnk[0] & trx, 2'b00};
      led_serial_pkg::MODE_L100_ACT: t = {lnk[1], lnk[1] & trx, 2'b00};
      led_serial_pkg::MODE_L10_ACT: t = {lnk[2], lnk[2] & trx, 2'b00};
      led_serial_pkg::MODE_L100_1000: t = {|lnk[1:0], (|lnk[1:0]) & trx, 2'b00};
      led_serial_pkg::MODE_L10_1000: t = {lnk[2] | lnk[0], (lnk[2] | lnk[0]) & trx, 2'b00};
      led_serial_pkg::MODE_L10_100: t = {|lnk[2:1], (|lnk[2:1]) & trx, 2'b00};
      led_serial_pkg::MODE_DUPLEX_COL: t = {any_link & fd, any_link & ~fd & act[0], 2'b00};
      led_serial_pkg::MODE_COLLISION: t = {1'b0, act[0], 2'b10};
      led_serial_pkg::MODE_ACTIVITY: t = {1'b0, trx, 2'b10};
      led_serial_pkg::MODE_ANEG_FAULT: t = {fault, 3'b000};
      led_serial_pkg::MODE_FORCE_ON: t = 4'b1000;
      led_serial_pkg::MODE_L1000X: t = {lnk[3], 3'b000};
      led_serial_pkg::MODE_L100FX: t = {lnk[4], 3'b000};
      led_serial_pkg::MODE_ACT_1000X: t = {1'b0, act[3], 2'b10};
      led_serial_pkg::MODE_ACT_100FX: t = {1'b0, act[4], 2'b10};
      led_serial_pkg::MODE_X_FORCE_ON: t = 4'b1001;
      led_serial_pkg::MODE_TX_ACT: t = {1'b0, act[1], 2'b10};
      led_serial_pkg::MODE_RX_ACT: t = {1'b0, act[2], 2'b10};
      default: t = 4'h0; // Reserved, force off and serial codes stay de-asserted
    endcase
    return t;
  endfunction : mode_terms

  // Returns {asserted, no_pulse}
  function automatic logic [1:0] led_eval(input logic [4:0] mode, input logic [4:0] lnk,
                                          input logic fd, input logic fault,
                                          input logic [4:0] act_raw, input logic [4:0] act_str,
                                          input logic combine, input logic stretch,
                                          input logic blink);
    logic [3:0] tr;
    logic [3:0] ts;
    logic ce;
    logic secx;
    logic on;
    tr = mode_terms(mode, lnk, fd, fault, act_raw);
    ts = mode_terms(mode, lnk, fd, fault, act_str);
    ce = combine | tr[1];
    secx = stretch ? ts[2] : tr[2];
    // A lit link LED goes dark for a stretched burst so the stretch stays visible
    on = (tr[3] & ~(ce & secx)) | (ce & secx & (stretch ? ~tr[3] : blink));
    return {on, tr[0]};
  endfunction : led_eval

  function automatic logic is_forced(input logic [4:0] mode);
    return mode == led_serial_pkg::MODE_FORCE_OFF || mode == led_serial_pkg::MODE_FORCE_ON ||
           mode == led_serial_pkg::MODE_X_FORCE_OFF || mode == led_serial_pkg::MODE_X_FORCE_ON;
  endfunction : is_forced

  function automatic logic [4:0] slot_mode(input logic [3:0] pos);
    logic [4:0] m;
    case (pos)
      4'h0: m = led_serial_pkg::MODE_LINK_ACT;
      4'h1: m = led_serial_pkg::MODE_L1000_ACT;
      4'h2: m = led_serial_pkg::MODE_L100_ACT;
      4'h3: m = led_serial_pkg::MODE_L10_ACT;
      4'h5: m = led_serial_pkg::MODE_DUPLEX_COL;
      4'h6: m = led_serial_pkg::MODE_COLLISION;
      4'h7: m = led_serial_pkg::MODE_ACTIVITY;
      4'h9: m = led_serial_pkg::MODE_TX_ACT;
      4'ha: m = led_serial_pkg::MODE_RX_ACT;
      4'hb: m = led_serial_pkg::MODE_ANEG_FAULT;
      default: m = led_serial_pkg::MODE_RSVD_A;
    endcase
    return m;
  endfunction : slot_mode

  // Registers
  logic [15:0] mode_reg [4];
  logic [15:0] behav_reg [4];
  logic [15:0] ext_ctrl_reg;
  logic [15:0] polarity_reg;
  logic [15:0] drive_reg;
  logic [15:0] swap_reg;
  logic [NPIN-1:0] led_state_reg;
  logic [15:0] read_next;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      for (int p = 0; p < 4; p++) begin
        mode_reg[p] <= led_serial_pkg::MODE_RESET;
        behav_reg[p] <= led_serial_pkg::BEHAV_RESET;
      end
      ext_ctrl_reg <= led_serial_pkg::EXT_CTRL_RESET;
      polarity_reg <= led_serial_pkg::POLARITY_RESET;
      drive_reg <= led_serial_pkg::DRIVE_RESET;
      swap_reg <= led_serial_pkg::SWAP_RESET;
    end else if (reg_wr) begin
      for (int p = 0; p < 4; p++) begin
        if (reg_addr == led_serial_pkg::MODE_OFS + 4'(p)) begin
          mode_reg[p] <= reg_wdata;
        end
        if (reg_addr == led_serial_pkg::BEHAV_OFS + 4'(p)) begin
          behav_reg[p] <= reg_wdata;
        end
      end
      if (reg_addr == led_serial_pkg::EXT_CTRL_OFS) begin
        ext_ctrl_reg <= reg_wdata;
      end
      if (reg_addr == led_serial_pkg::POLARITY_OFS) begin
        polarity_reg <= reg_wdata;
      end
      if (reg_addr == led_serial_pkg::DRIVE_OFS) begin
        drive_reg <= reg_wdata;
      end
      if (reg_addr == led_serial_pkg::SWAP_OFS) begin
        swap_reg <= reg_wdata;
      end
    end
  end

  always_comb begin
    read_next = 16'h0000;
    for (int p = 0; p < 4; p++) begin
      if (reg_addr == led_serial_pkg::MODE_OFS + 4'(p)) begin
        read_next = mode_reg[p];
      end
      if (reg_addr == led_serial_pkg::BEHAV_OFS + 4'(p)) begin
        read_next = behav_reg[p];
      end
    end
    case (reg_addr)
      led_serial_pkg::EXT_CTRL_OFS: read_next = ext_ctrl_reg;
      led_serial_pkg::POLARITY_OFS: read_next = polarity_reg;
      led_serial_pkg::DRIVE_OFS: read_next = drive_reg;
      led_serial_pkg::SWAP_OFS: read_next = swap_reg;
      led_serial_pkg::STATE_OFS: read_next = led_state_reg;
      default: ;
    endcase
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= reg_rd ? read_next : 16'h0000;
    end
  end

  // Time base: one tick per 25 ms drives blink, stretch and the boot blink
  logic [TICK_W-1:0] tick_cnt_reg;
  logic tick;
  logic [3:0] tick_phase_reg;
  logic [1:0] rate;
  logic blink;
  assign tick = tick_cnt_reg == TICK_W'(BASE_TICK_CYC - 1);
  assign rate = behav_reg[0][led_serial_pkg::RATE_LSB +: 2];
  assign blink = tick_phase_reg[rate];

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      tick_cnt_reg <= '0;
      tick_phase_reg <= 4'h0;
    end else begin
      tick_cnt_reg <= tick ? '0 : tick_cnt_reg + 1'b1;
      if (tick) begin
        tick_phase_reg <= tick_phase_reg + 4'h1;
      end
    end
  end

  // Boot blink runs from reset release; clearing the enable ends it at once
  logic [5:0] boot_cnt_reg;
  logic boot_active;
  assign boot_active = boot_cnt_reg != 6'h00 && ext_ctrl_reg[led_serial_pkg::BOOT_BLINK_BIT];

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      boot_cnt_reg <= 6'(led_serial_pkg::BOOT_TICKS);
    end else if (tick && boot_cnt_reg != 6'h00) begin
      boot_cnt_reg <= boot_cnt_reg - 6'h01;
    end
  end

  // Low-duty pulse waveform
  logic [15:0] pulse_cnt_reg;
  logic [15:0] pulse_period;
  logic [15:0] pulse_high;
  logic pulse_on;
  logic pulse_en;
  assign pulse_en = ext_ctrl_reg[led_serial_pkg::PULSE_EN_BIT];
  assign pulse_period = 16'(led_serial_pkg::PULSE_PERIOD_CYC)
                        << ext_ctrl_reg[led_serial_pkg::PULSE_FREQ_LSB +: 2];
  assign pulse_high = 16'(16'(led_serial_pkg::PULSE_STEP_CYC)
                      * (16'(ext_ctrl_reg[led_serial_pkg::PULSE_WIDTH_LSB +: 2]) + 16'h1))
                      << ext_ctrl_reg[led_serial_pkg::PULSE_FREQ_LSB +: 2];
  assign pulse_on = pulse_cnt_reg < pulse_high;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pulse_cnt_reg <= 16'h0000;
    end else begin
      pulse_cnt_reg <= (pulse_cnt_reg >= pulse_period - 16'h1) ? 16'h0000 : pulse_cnt_reg + 16'h1;
    end
  end

  // Per-port status and pulse stretchers on {100fx, 1000x, rx, tx, collision}
  logic [4:0] lnk_v [4];
  logic [4:0] act_raw [4];
  logic [4:0] act_str [4];
  logic [4:0] stretch_len;
  assign stretch_len = 5'(6'h02 << rate) + 5'h01;

  for (genvar p = 0; p < 4; p++) begin : g_port
    assign lnk_v[p] = {link_100fx[p], link_1000x[p], link10[p], link100[p], link1000[p]};
    assign act_raw[p] = {activity_100fx[p], activity_1000x[p], rx_activity[p], tx_activity[p],
                         collision[p]};
    for (genvar s = 0; s < 5; s++) begin : g_stretch
      logic str_reg;
      logic seen_reg;
      logic [4:0] hold_reg;
      assign act_str[p][s] = str_reg;
      always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
          str_reg <= 1'b0;
          seen_reg <= 1'b0;
          hold_reg <= 5'h00;
        end else begin
          // Short bursts during a dark hold are remembered, not lost
          if (hold_reg == 5'h00 && !str_reg && (act_raw[p][s] || seen_reg)) begin
            str_reg <= 1'b1;
            hold_reg <= stretch_len;
            seen_reg <= 1'b0;
          end else if (hold_reg == 5'h00 && str_reg && !act_raw[p][s]) begin
            str_reg <= 1'b0;
            hold_reg <= stretch_len;
          end else begin
            if (tick && hold_reg != 5'h00) begin
              hold_reg <= hold_reg - 5'h01;
            end
            if (act_raw[p][s] && !str_reg) begin
              seen_reg <= 1'b1;
            end
          end
        end
      end
    end
  end

  // Pin evaluation
  logic swap;
  logic serial_mode;
  logic [NPIN-1:0] pin_active;
  logic [NPIN-1:0] pin_assert;
  assign swap = swap_reg[led_serial_pkg::SWAP_BIT];
  assign serial_mode = mode_reg[0][3:0] == led_serial_pkg::MODE_SERIAL
                       && !ext_ctrl_reg[led_serial_pkg::EXT_EN_LSB];

  for (genvar i = 0; i < NPIN; i++) begin : g_pin
    localparam int PP = i / 4;
    localparam int LL = i % 4;
    logic [1:0] lp;
    logic [4:0] mode;
    logic [1:0] ev;
    assign lp = swap ? 2'(3 - PP) : 2'(PP);
    assign mode = {(LL == 0) ? ext_ctrl_reg[led_serial_pkg::EXT_EN_LSB + lp] : 1'b0,
                   mode_reg[lp][LL * 4 +: 4]};
    assign ev = led_eval(mode, lnk_v[lp], full_duplex[lp], aneg_fault[lp], act_raw[lp],
                         act_str[lp], behav_reg[lp][led_serial_pkg::COMBINE_LSB + LL],
                         behav_reg[lp][led_serial_pkg::STRETCH_LSB + LL], blink);
    assign pin_assert[i] = ev[1];
    assign pin_active[i] = (boot_active && !is_forced(mode)) ? blink
                           : ev[1] & (pulse_on | ~pulse_en | ev[0]);
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      led_state_reg <= '0;
    end else begin
      led_state_reg <= pin_assert;
    end
  end

  // Serializer: data settles in the low half, receiver samples on the rise
  led_serial_pkg::ser_state_type ser_state_reg;
  led_serial_pkg::ser_state_type ser_state_next;
  logic [HALF_W-1:0] half_cnt_reg;
  logic [1:0] slot_port_reg;
  logic [3:0] slot_pos_reg;
  logic ser_clk_reg;
  logic ser_data_reg;
  logic half_done;
  logic [1:0] sp;
  logic [1:0] slot_ev;
  logic slot_bit;
  assign half_done = half_cnt_reg == HALF_W'(SER_HALF_CYC - 1);
  assign sp = swap ? 2'd3 - slot_port_reg : slot_port_reg;
  assign slot_ev = led_eval(slot_mode(slot_pos_reg), lnk_v[sp], full_duplex[sp], aneg_fault[sp],
                            act_raw[sp], act_str[sp],
                            behav_reg[sp][led_serial_pkg::COMBINE_LSB],
                            behav_reg[sp][led_serial_pkg::STRETCH_LSB], blink);
  assign slot_bit = (slot_pos_reg == 4'(led_serial_pkg::ANEG_SLOT) && slot_port_reg[1])
                    ? 1'b0 : slot_ev[1];

  always_comb begin
    ser_state_next = ser_state_reg;
    case (ser_state_reg)
      led_serial_pkg::SER_IDLE: begin
        if (serial_mode) begin
          ser_state_next = led_serial_pkg::SER_LOW;
        end
      end
      led_serial_pkg::SER_LOW: begin
        if (!serial_mode) begin
          ser_state_next = led_serial_pkg::SER_IDLE;
        end else if (half_done) begin
          ser_state_next = led_serial_pkg::SER_HIGH;
        end
      end
      led_serial_pkg::SER_HIGH: begin
        if (!serial_mode) begin
          ser_state_next = led_serial_pkg::SER_IDLE;
        end else if (half_done) begin
          ser_state_next = led_serial_pkg::SER_LOW;
        end
      end
      default: ser_state_next = led_serial_pkg::SER_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ser_state_reg <= led_serial_pkg::SER_IDLE;
      half_cnt_reg <= '0;
    end else begin
      ser_state_reg <= ser_state_next;
      half_cnt_reg <= (ser_state_next != ser_state_reg) ? '0 : half_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      slot_port_reg <= 2'd0;
      slot_pos_reg <= 4'h0;
    end else if (ser_state_reg == led_serial_pkg::SER_IDLE) begin
      slot_port_reg <= 2'd0;
      slot_pos_reg <= 4'h0;
    end else if (ser_state_reg == led_serial_pkg::SER_HIGH && half_done) begin
      if (slot_pos_reg == 4'(led_serial_pkg::SLOTS_PER_PORT - 1)) begin
        slot_pos_reg <= 4'h0;
        slot_port_reg <= slot_port_reg + 2'd1; // Wraps after the 48th slot
      end else begin
        slot_pos_reg <= slot_pos_reg + 4'h1;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ser_clk_reg <= 1'b0;
      ser_data_reg <= 1'b0;
    end else begin
      ser_clk_reg <= ser_state_reg == led_serial_pkg::SER_HIGH;
      // Sampled once at the start of the low half so it is frozen over the rise
      if (ser_state_reg == led_serial_pkg::SER_LOW && half_cnt_reg == '0) begin
        ser_data_reg <= slot_bit;
      end
    end
  end

  // Pin drivers
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      led_out <= '1;
      led_oe <= '0;
    end else begin
      for (int i = 0; i < NPIN; i++) begin
        // Active level is low unless the LED's polarity bit inverts it
        led_out[i] <= pin_active[i] ~^ polarity_reg[led_serial_pkg::POLARITY_LSB + (i % 4)];
        led_oe[i] <= pin_active[i] | ~drive_reg[led_serial_pkg::DRIVE_BIT];
      end
      if (serial_mode) begin
        led_out[0] <= ser_data_reg ~^ polarity_reg[led_serial_pkg::POLARITY_LSB];
        led_oe[0] <= 1'b1;
        led_out[1] <= ser_clk_reg;
        led_oe[1] <= 1'b1;
      end
    end
  end
endmodule : led_status_serializer
`default_nettype wire

// ===== verif/led_shift_receiver.sv
// Far-end shift register that captures the serial status stream
`timescale 1ns/1ps
`default_nettype none
module led_shift_receiver (
  input wire logic reset,
  input wire logic ser_clk,
  input wire logic ser_data,
  output logic [47:0] frame,
  output int count
);
  // Captures only on the rising serial clock edge
  always @(posedge ser_clk or posedge reset) begin
    if (reset) begin
      count <= 0;
    end else begin
      frame <= {frame[46:0], ser_data};
      count <= count + 1;
    end
  end
endmodule : led_shift_receiver
`default_nettype wire

// ===== verif/led_status_serializer_properties.sv
// Port checker for the status LED controller
`timescale 1ns/1ps
`default_nettype none
module led_status_serializer_properties #(
  parameter int SER_HALF_CYC = 8
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic [15:0] led_out,
  input wire logic [15:0] led_oe
);
  logic ser_reg, ext_reg, drv_reg, last_reg;
  logic [3:0] pol_reg;
  int run_reg, age_reg;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      {ser_reg, ext_reg, drv_reg, last_reg, pol_reg} <= 8'h30;
      run_reg <= 0;
      age_reg <= 0;
    end else begin
      last_reg <= led_out[1];
      run_reg <= (led_out[1] != last_reg) ? 0 : run_reg + 1;
      // Saturates so the entry transient is left out for good
      age_reg <= (ser_reg && !ext_reg) ? ((age_reg < 999) ? age_reg + 1 : 999) : 0;
      if (reg_wr && reg_addr == 4'h0) ser_reg <= reg_wdata[3:0] == 4'hd;
      if (reg_wr && reg_addr == 4'h8) ext_reg <= reg_wdata[12];
      if (reg_wr && reg_addr == 4'h9) pol_reg <= reg_wdata[13:10];
      if (reg_wr && reg_addr == 4'ha) drv_reg <= reg_wdata[9];
    end
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  AST_HALF_LEN:
    assert property (age_reg > 4 * SER_HALF_CYC && led_out[1] != last_reg |->
      run_reg == SER_HALF_CYC - 1) else $error("serial clock half length");
  AST_DATA_STABLE:
    assert property (age_reg > 4 * SER_HALF_CYC && $rose(led_out[1]) |->
      $stable(led_out[0]) ##1 $stable(led_out[0])) else $error("data moved at rise");
  // Data and clock pins lag the state by the same two registers, so data moves with the fall
  AST_DATA_IN_LOW:
    assert property (age_reg > 4 * SER_HALF_CYC && $changed(led_out[0]) |->
      !led_out[1] && last_reg) else $error("data moved off the clock fall");
  AST_RD_IDLE:
    assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000) else $error("read data idle");
  AST_RD_POL:
    assert property ($past(reg_rd) && $past(reg_addr) == 4'h9 |->
      reg_rdata[13:10] == $past(pol_reg)) else $error("polarity readback");
  AST_ACTIVE_DRIVEN:
    assert property (pol_reg == 4'h0 && $past(pol_reg, 2) == 4'h0 |->
      &(led_oe[15:2] | led_out[15:2])) else $error("active pin undriven");
  AST_IDLE_FLOAT:
    assert property (drv_reg && $past(drv_reg, 2) && pol_reg == 4'h0 |->
      !(|(led_oe[15:2] & led_out[15:2]))) else $error("idle pin driven");
  AST_DRIVEN_ALL:
    assert property (!drv_reg && !$past(drv_reg, 2) |-> &led_oe[15:2])
      else $error("pin not driven");
endmodule : led_status_serializer_properties
bind led_status_serializer led_status_serializer_properties #(.SER_HALF_CYC(SER_HALF_CYC))
  chk (.ref_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .led_out, .led_oe);
`default_nettype wire

// ===== verif/testbench.sv
// Bench for the status LED controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic ref_clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0] reg_addr = 4'h0, l1, l2, l3, fd, tx, rx, af, z = 4'h0, v;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, led_out, led_oe;
  logic [47:0] frame;
  int count, n0, fails = 0, checked = 0;
  always #12.5 ref_clk = ~ref_clk;
  assign v = l1 | l2 | l3;
  led_status_serializer #(.BASE_TICK_CYC(20)) dut (.ref_clk, .reset, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .link1000(l1), .link100(l2), .link10(l3), .link_1000x(z),
    .link_100fx(z), .full_duplex(fd), .collision(z), .tx_activity(tx), .rx_activity(rx),
    .activity_1000x(z), .activity_100fx(z), .aneg_fault(af), .led_out, .led_oe);
  led_shift_receiver far_end (.reset, .ser_clk(led_out[1]), .ser_data(led_out[0]), .frame,
    .count);
  task automatic chk_led(input logic [47:0] got, exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %h, expected %h", $time, got, exp);
    end
  endtask : chk_led
  task automatic chk_reg(input logic [15:0] got, exp);
    chk_led({32'h0, got}, {32'h0, exp});
  endtask : chk_reg
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk_reg(reg_rdata, exp);
  endtask : rd
  // Pin levels of one frame, slot 0 shifted first; activity held so stretch stays lit
  function automatic logic [47:0] exp_frame(input logic sw, p);
    logic [47:0] e;
    logic l;
    int q;
    for (int g = 0; g < 4; g++) begin
      q = sw ? 3 - g : g;
      l = l1[q] | l2[q] | l3[q];
      e = {e[35:0], ~({l, l1[q], l2[q], l3[q], 1'b0, fd[q] & l, 1'b0, tx[q] | rx[q], 1'b0,
        tx[q], rx[q], g < 2 && af[q]} ^ {12{p}})};
    end
    return e;
  endfunction : exp_frame
  task automatic give_verdict;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (30000) @(posedge ref_clk);
    fails++;
    give_verdict;
  end
  initial begin
    {l1, l2, l3, fd, tx, rx, af} = 28'h0;
    void'($urandom(33009));
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    rd(4'h4, 16'h000f);
    rd(4'h8, 16'h0801);
    rd(4'ha, 16'h0200);
    rd(4'hf, 16'h0000);
    for (int k = 0; k < 4; k++) begin
      @(posedge ref_clk);
      reset <= 1'b1;
      {l1, l2, l3, fd, tx, rx, af} <= 28'($urandom);
      repeat (10) @(posedge ref_clk);
      reset <= 1'b0;
      wr(4'h8, 16'h2000);
      wr(4'h9, {5'h00, k[1], 10'h000});
      rd(4'h9, {5'h00, k[1], 10'h000});
      wr(4'ha, {6'h00, !k[1], 9'h000});
      wr(4'hb, {15'h0000, k[0]});
      for (int p = 4; p < 8; p++) wr(4'(p), 16'h00f0);
      wr(4'h1, 16'h0005);
      n0 = count;
      wr(4'h0, 16'hef0d);
      for (int f = 1; f < 3; f++) begin
        for (int i = 0; i < 2000 && count < n0 + 48 * f; i++) @(posedge ref_clk);
        chk_led(frame, exp_frame(k[0], k[1]));
      end
      if (!k[0]) begin
        chk_led({46'h0, led_out[3:2]}, 48'h2);
        chk_led({47'h0, led_out[4]}, {47'h0, k[1]});
        rd(4'hc, {{4{v[3]}}, {4{v[2]}}, {3{v[1]}}, 3'b101, v[0], 1'b0});
      end
    end
    give_verdict;
  end
endmodule : testbench
`default_nettype wire
